// File: bench/ccx_exec_tb.sv
// self-checking bench for the execution unit
// assumes every accepted op ends with one done pulse
`timescale 1ns/1ps
`default_nettype none
module ccx_exec_tb
    import ccx_pkg::*;
;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        op_valid = 1'b0;
    ccx_op_t     op_code = CCX_OP_NONE;
    ccx_cmp_t    cmp_mode = CCX_CMP_ACC_DIR;
    ccx_tgt_t    tgt_mode = CCX_TGT_ACC;
    logic        bit_is_carry = 1'b0;
    logic        bit_is_port = 1'b0;
    logic [15:0] pc_in = 16'h0000;
    logic [7:0]  working_reg_in = 8'h00;
    logic [7:0]  direct_in = 8'h00;
    logic [7:0]  index_mem_in = 8'h00;
    logic [7:0]  imm_in = 8'h00;
    logic [7:0]  rel_in = 8'h00;
    logic        bit_in = 1'b0;
    logic        bit_latch_in = 1'b0;
    logic        ld = 1'b0;
    logic [7:0]  ld_acc = 8'h00;
    logic [7:0]  ld_b = 8'h00;
    logic        ld_cy = 1'b0;
    logic        ld_ac = 1'b0;
    logic        ld_sg = 1'b0;
    logic [7:0]  acc_reg, b_reg, acc_out, b_out, byte_out;
    logic        cy_reg, ac_reg, sg_reg, busy, done, pc_we, acc_we, b_we, byte_we;
    logic        bit_we, bit_out, carry_we, carry_out, sign_we, sign_out;
    logic [15:0] pc_out;
    ccx_tgt_t    byte_tgt;
    int          num_errors = 0;
    int          comparisons = 0;
    int          lat1 = 0;
    int          lat = 0;

    always #20 clock = ~clock;

    ccx_exec #(.DW(8)) ccx_exec_i (.clock(clock), .resetn(resetn), .op_valid(op_valid),
        .op_code(op_code), .cmp_mode(cmp_mode), .tgt_mode(tgt_mode),
        .bit_is_carry(bit_is_carry), .bit_is_port(bit_is_port), .pc_in(pc_in),
        .acc_in(acc_reg), .b_in(b_reg), .working_reg_in(working_reg_in),
        .direct_in(direct_in), .index_mem_in(index_mem_in), .imm_in(imm_in),
        .rel_in(rel_in), .bit_in(bit_in), .bit_latch_in(bit_latch_in), .carry_in(cy_reg),
        .nibble_carry_flag(ac_reg), .sign_error_flag(sg_reg), .busy(busy), .done(done),
        .pc_we(pc_we), .pc_out(pc_out), .acc_we(acc_we), .acc_out(acc_out), .b_we(b_we),
        .b_out(b_out), .byte_we(byte_we), .byte_tgt(byte_tgt), .byte_out(byte_out),
        .bit_we(bit_we), .bit_out(bit_out), .carry_we(carry_we), .carry_out(carry_out),
        .sign_we(sign_we), .sign_out(sign_out));

    ccx_regfile_model ccx_regfile_model_i (.clock(clock), .resetn(resetn), .ld(ld),
        .ld_acc(ld_acc), .ld_b(ld_b), .ld_cy(ld_cy), .ld_ac(ld_ac), .ld_sg(ld_sg),
        .acc_we(acc_we), .acc_d(acc_out), .b_we(b_we), .b_d(b_out), .carry_we(carry_we),
        .carry_d(carry_out), .sign_we(sign_we), .sign_d(sign_out), .acc_ff(acc_reg),
        .b_ff(b_reg), .carry_ff(cy_reg), .ac_ff(ac_reg), .sign_ff(sg_reg));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic load(input logic [7:0] a, input logic [7:0] b, input logic cy,
                        input logic ac, input logic sg);
        @(negedge clock);
        ld = 1'b1;
        ld_acc = a;
        ld_b = b;
        ld_cy = cy;
        ld_ac = ac;
        ld_sg = sg;
        @(negedge clock);
        ld = 1'b0;
    endtask

    // one-cycle request, then bounded wait for done; returns in the done cycle
    task automatic issue(input ccx_op_t op);
        @(negedge clock);
        op_code = op;
        op_valid = 1'b1;
        @(negedge clock);
        op_valid = 1'b0;
        lat = 0;
        while (done !== 1'b1 && lat < 20)
        begin
            @(negedge clock);
            lat++;
        end
        chk("done", done, 1'b1);
    endtask

    task automatic t_acc;
        load(8'h5c, 8'h00, 1'b1, 1'b1, 1'b1);
        issue(CCX_OP_INV_ACC);
        lat1 = lat;
        chk("inv acc", {acc_we, acc_out}, 9'h1a3);
        issue(CCX_OP_ZERO_ACC);
        chk("zero acc", {acc_we, acc_out}, 9'h100);
        chk("zero lat", lat, lat1);
        @(negedge clock);
        chk("acc flags", {cy_reg, ac_reg, sg_reg}, 3'b111);
    endtask

    task automatic t_bit;
        load(8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
        bit_is_carry = 1'b1;
        issue(CCX_OP_INV_BIT);
        chk("inv carry", {carry_we, carry_out, bit_we}, 3'b100);
        issue(CCX_OP_INV_BIT);
        chk("inv carry again", {carry_we, carry_out, bit_we}, 3'b110);
        issue(CCX_OP_ZERO_BIT);
        chk("zero carry", {carry_we, carry_out, bit_we}, 3'b100);
        bit_is_carry = 1'b0;
        bit_is_port = 1'b1;
        bit_latch_in = 1'b1;
        issue(CCX_OP_INV_BIT);
        chk("inv port bit", {bit_we, bit_out, carry_we}, 3'b100);
        bit_is_port = 1'b0;
        issue(CCX_OP_INV_BIT);
        chk("inv bit", {bit_we, bit_out, carry_we}, 3'b110);
        issue(CCX_OP_ZERO_BIT);
        chk("zero bit", {bit_we, bit_out, carry_we, sign_we}, 4'b1000);
        chk("bit lat", lat, lat1);
    endtask

    task automatic t_compare;
        logic [7:0]  f;
        logic [7:0]  s;
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 3; k++)
            begin
                f = 8'h56;
                s = (k == 0) ? 8'h60 : (k == 1) ? 8'h56 : 8'h34;
                load((m < 2) ? f : s, 8'h11, !(f < s), 1'b0, 1'b0);
                working_reg_in = (m == 3) ? s : f;
                index_mem_in = (m == 2) ? s : f;
                direct_in = (m == 0) ? s : f;
                imm_in = (m == 0) ? f : s;
                rel_in = 8'hf0;
                pc_in = 16'h00fe;
                cmp_mode = ccx_cmp_t'(m[1:0]);
                issue(CCX_OP_CMP_BR);
                chk("cmp pc", {pc_we, pc_out}, {1'b1, 16'h0101 + ((f != s) ? 16'hfff0 : 16'h0)});
                chk("cmp lat", lat, lat1 + 1);
                chk("cmp carry", {carry_we, carry_out}, {1'b1, f < s});
                chk("cmp untouched", {acc_we, byte_we, b_we}, 3'b000);
            end
    endtask

    task automatic t_bcd;
        logic [7:0] a [8] = '{8'h45, 8'h4a, 8'h41, 8'ha5, 8'h9a, 8'hbe, 8'hc9, 8'h12};
        logic [7:0] r [8] = '{8'h45, 8'h50, 8'h47, 8'h05, 8'h00, 8'h24, 8'h29, 8'h72};
        logic [7:0] fl = 8'b00000100;
        logic [7:0] ci = 8'b10000000;
        logic [7:0] co = 8'b11111000;
        for (int i = 0; i < 8; i++)
        begin
            load(a[i], 8'h00, ci[i], fl[i], 1'b1);
            issue(CCX_OP_BCD);
            chk("bcd acc", acc_out, r[i]);
            chk("bcd lat", lat, lat1);
            @(negedge clock);
            chk("bcd carry", {cy_reg, sg_reg}, {co[i], 1'b1});
        end
    endtask

    task automatic t_dec;
        logic [7:0] e [4] = '{8'hff, 8'h0f, 8'h7f, 8'h00};
        for (int t = 0; t < 4; t++)
        begin
            load(8'h00, 8'h00, 1'b1, 1'b1, 1'b1);
            working_reg_in = 8'h10;
            direct_in = 8'h80;
            index_mem_in = 8'h01;
            tgt_mode = ccx_tgt_t'(t[1:0]);
            issue(CCX_OP_SUB_ONE);
            chk("dec data", byte_out, e[t]);
            chk("dec we", {byte_we, acc_we}, 2'b10);
            chk("dec tgt", byte_tgt, t);
            chk("dec lat", lat, lat1);
            chk("dec flags", {carry_we, sign_we}, 2'b00);
        end
    endtask

    task automatic t_div;
        logic [7:0] a [3] = '{8'hfb, 8'h05, 8'h37};
        logic [7:0] b [3] = '{8'h12, 8'h09, 8'h00};
        logic [7:0] q [3] = '{8'h0d, 8'h00, CCX_DIV0_QUOT};
        logic [7:0] m [3] = '{8'h11, 8'h05, 8'h37};
        for (int i = 0; i < 3; i++)
        begin
            load(a[i], b[i], 1'b1, 1'b0, i != 2);
            issue(CCX_OP_DIVIDE);
            chk("div lat", lat, lat1 + 3);
            @(negedge clock);
            chk("div acc", acc_reg, q[i]);
            chk("div b", b_reg, m[i]);
            chk("div flags", {cy_reg, sg_reg}, {1'b0, i == 2});
        end
    endtask

    initial
    begin
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        chk("reset", {busy, done, acc_we, pc_we}, 4'h0);
        t_acc;
        t_bit;
        t_compare;
        t_bcd;
        t_dec;
        t_div;
        end_of_test;
    end

    // run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        num_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire

// File: bench/ccx_regfile_model.sv
// register-file model: accumulator, b register and status flags
// assumes the bench preloads it while the execution unit is idle
`timescale 1ns/1ps
`default_nettype none
module ccx_regfile_model
    import ccx_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       ld,
    input  wire logic [7:0] ld_acc,
    input  wire logic [7:0] ld_b,
    input  wire logic       ld_cy,
    input  wire logic       ld_ac,
    input  wire logic       ld_sg,
    input  wire logic       acc_we,
    input  wire logic [7:0] acc_d,
    input  wire logic       b_we,
    input  wire logic [7:0] b_d,
    input  wire logic       carry_we,
    input  wire logic       carry_d,
    input  wire logic       sign_we,
    input  wire logic       sign_d,
    output logic      [7:0] acc_ff,
    output logic      [7:0] b_ff,
    output logic            carry_ff,
    output logic            ac_ff,
    output logic            sign_ff
);
    // registers change only on a strobe, so unchanged flags stay visible
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            acc_ff   <= CCX_RST_BYTE;
            b_ff     <= CCX_RST_BYTE;
            carry_ff <= 1'b0;
            ac_ff    <= 1'b0;
            sign_ff  <= 1'b0;
        end
        else if (ld)
        begin
            acc_ff   <= ld_acc;
            b_ff     <= ld_b;
            carry_ff <= ld_cy;
            ac_ff    <= ld_ac;
            sign_ff  <= ld_sg;
        end
        else
        begin
            if (acc_we)
                acc_ff <= acc_d;
            if (b_we)
                b_ff <= b_d;
            if (carry_we)
                carry_ff <= carry_d;
            if (sign_we)
                sign_ff <= sign_d;
        end
    end
endmodule
`default_nettype wire

// File: pkg/ccx_pkg.sv
// constants for the compare/clear/invert/bcd/decrement/divide execution unit
// assumes a sequencer that issues one decoded operation with its operands
package ccx_pkg;
    localparam int          CCX_DW           = 8;
    localparam logic [7:0]  CCX_BCD_SIX      = 8'h06;
    localparam logic [7:0]  CCX_BCD_SIX_HI   = 8'h60;
    localparam logic [3:0]  CCX_NIBBLE_MAX   = 4'h9;
    localparam int          CCX_COMPARE_BRANCH_UNEQUAL_BYTES   = 3;
    localparam int          CCX_COMPARE_BRANCH_UNEQUAL_CYCLES  = 2;
    localparam int          CCX_DIV_CYCLES   = 4;
    localparam logic [7:0]  CCX_DIV0_QUOT    = 8'hff;
    localparam logic [7:0]  CCX_RST_BYTE     = 8'h00;
    // operation codes given by the sequencer
    typedef enum logic [3:0] {
        CCX_OP_NONE      = 4'h0,
        CCX_OP_CMP_BR    = 4'h1,
        CCX_OP_ZERO_ACC  = 4'h2,
        CCX_OP_ZERO_BIT  = 4'h3,
        CCX_OP_INV_ACC   = 4'h4,
        CCX_OP_INV_BIT   = 4'h5,
        CCX_OP_BCD       = 4'h6,
        CCX_OP_SUB_ONE   = 4'h7,
        CCX_OP_DIVIDE    = 4'h8
    } ccx_op_t;
    // compare operand pairing
    typedef enum logic [1:0] {
        CCX_CMP_ACC_DIR  = 2'h0,
        CCX_CMP_ACC_IMM  = 2'h1,
        CCX_CMP_REG_IMM  = 2'h2,
        CCX_CMP_IND_IMM  = 2'h3
    } ccx_cmp_t;
    // decrement target
    typedef enum logic [1:0] {
        CCX_TGT_ACC      = 2'h0,
        CCX_TGT_REG      = 2'h1,
        CCX_TGT_DIR      = 2'h2,
        CCX_TGT_IND      = 2'h3
    } ccx_tgt_t;
    typedef enum logic [2:0] {
        CCX_ST_IDLE      = 3'b001,
        CCX_ST_CMP       = 3'b010,
        CCX_ST_DIV       = 3'b100
    } ccx_state_t;
endpackage

// File: src/ccx_divider.sv
// restoring unsigned divider, four quotient bits per clock
// assumes start is a one-cycle pulse while idle
`timescale 1ns/1ps
`default_nettype none
module ccx_divider
    import ccx_pkg::*;
#(
    parameter int WIDTH = 8
)(
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] dividend,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  done,
    output logic      [WIDTH-1:0] quotient,
    output logic      [WIDTH-1:0] remainder
);
    // one cycle loads, one hands the result over, the rest iterate
    localparam int PASSES = CCX_DIV_CYCLES - 2;
    localparam int STEPS  = WIDTH / PASSES;
    if (WIDTH != CCX_DW || WIDTH % PASSES != 0)
    begin : g_bad_width
        $error("ccx_divider width must equal the datapath width");
    end
    logic [WIDTH-1:0] quo_ff, nxt_quo;
    logic [WIDTH-1:0] rem_ff, nxt_rem;
    logic [WIDTH-1:0] dsr_ff, nxt_dsr;
    logic [3:0]       cnt_ff, nxt_cnt;
    logic             done_ff, nxt_done;
    logic [WIDTH-1:0] rem_s [STEPS+1];
    logic [WIDTH-1:0] quo_s [STEPS+1];
    logic [WIDTH:0]   trial [STEPS];
    assign rem_s[0] = rem_ff;
    assign quo_s[0] = quo_ff;
    // chained restoring steps retire several quotient bits per clock
    for (genvar g = 0; g < STEPS; g++)
    begin : g_step
        assign trial[g]   = {rem_s[g], quo_s[g][WIDTH-1]} - {1'b0, dsr_ff};
        assign rem_s[g+1] = trial[g][WIDTH] ? {rem_s[g][WIDTH-2:0], quo_s[g][WIDTH-1]}
                                            : trial[g][WIDTH-1:0];
        assign quo_s[g+1] = {quo_s[g][WIDTH-2:0], !trial[g][WIDTH]};
    end
    always_comb
    begin
        nxt_quo  = quo_ff;
        nxt_rem  = rem_ff;
        nxt_dsr  = dsr_ff;
        nxt_cnt  = cnt_ff;
        nxt_done = 1'b0;
        if (start)
        begin
            nxt_quo = dividend;
            nxt_rem = '0;
            nxt_dsr = divisor;
            nxt_cnt = 4'(PASSES);
        end
        else if (cnt_ff != 4'h0)
        begin
            nxt_rem  = rem_s[STEPS];
            nxt_quo  = quo_s[STEPS];
            nxt_cnt  = cnt_ff - 4'h1;
            nxt_done = (cnt_ff == 4'h1);
        end
    end
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            quo_ff  <= '0;
            rem_ff  <= '0;
            dsr_ff  <= '0;
            cnt_ff  <= 4'h0;
            done_ff <= 1'b0;
        end
        else
        begin
            quo_ff  <= nxt_quo;
            rem_ff  <= nxt_rem;
            dsr_ff  <= nxt_dsr;
            cnt_ff  <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end
    assign done      = done_ff;
    assign quotient  = quo_ff;
    assign remainder = rem_ff;
endmodule
`default_nettype wire

// File: src/ccx_exec.sv
// execution unit: compare-branch, zero, invert, bcd correct, decrement, divide
// assumes the sequencer holds op inputs stable while busy and fetches operands
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - compare-branch: pc plus three, plus displacement if unequal; two cycles
// - compare-branch sets carry if first below second; operands untouched
// - compare pairings: acc/direct, acc/imm, reg/imm, indirect/imm
// - zero accumulator in one cycle, flags kept
// - zero carry or addressable bit in one cycle, other flags kept
// - invert accumulator in one cycle, flags kept
// - invert carry or addressable bit in one cycle, other flags kept
// - port bit/byte modify uses output latch, not pins
// - bcd: low nibble above nine or nibble carry adds six; carry only set
// - bcd: carry or high above nine adds sixty; carry only set; sign flag kept
// - bcd correction in one cycle adding 00, 06, 60 or 66
// - decrement subtracts one, wraps 00 to ff, no flags changed
// - decrement acc, reg, direct or indirect, one cycle each
// - divide: quotient to acc, remainder to b, clear carry and sign flag, four cycles
// - divide by zero sets sign flag, clears carry
module ccx_exec
    import ccx_pkg::*;
#(
    parameter int DW = 8
)(
    input  wire logic          clock,
    input  wire logic          resetn,
    input  wire logic          op_valid,
    input  wire ccx_op_t       op_code,
    input  wire ccx_cmp_t      cmp_mode,
    input  wire ccx_tgt_t      tgt_mode,
    input  wire logic          bit_is_carry,
    input  wire logic          bit_is_port,
    input  wire logic [15:0]   pc_in,
    input  wire logic [DW-1:0] acc_in,
    input  wire logic [DW-1:0] b_in,
    input  wire logic [DW-1:0] working_reg_in,
    input  wire logic [DW-1:0] direct_in,
    input  wire logic [DW-1:0] index_mem_in,
    input  wire logic [DW-1:0] imm_in,
    input  wire logic [DW-1:0] rel_in,
    input  wire logic          bit_in,
    input  wire logic          bit_latch_in,
    input  wire logic          carry_in,
    input  wire logic          nibble_carry_flag,
    input  wire logic          sign_error_flag,
    output logic               busy,
    output logic               done,
    output logic               pc_we,
    output logic [15:0]        pc_out,
    output logic               acc_we,
    output logic [DW-1:0]      acc_out,
    output logic               b_we,
    output logic [DW-1:0]      b_out,
    output logic               byte_we,
    output ccx_tgt_t           byte_tgt,
    output logic [DW-1:0]      byte_out,
    output logic               bit_we,
    output logic               bit_out,
    output logic               carry_we,
    output logic               carry_out,
    output logic               sign_we,
    output logic               sign_out
);
    if (DW != CCX_DW)
    begin : g_bad_width
        $error("ccx_exec supports only an eight bit datapath");
    end
    ccx_state_t     st_ff, nxt_st;
    logic [15:0]    pc_ff, nxt_pc;
    logic [DW-1:0]  acc_ff, nxt_acc, b_ff, nxt_b, byte_ff, nxt_byte;
    logic           pcw_ff, nxt_pcw, accw_ff, nxt_accw, bw_ff, nxt_bw;
    logic           bytew_ff, nxt_bytew, bitw_ff, nxt_bitw, bit_ff, nxt_bit;
    logic           cw_ff, nxt_cw, c_ff, nxt_c, sw_ff, nxt_sw, s_ff, nxt_s;
    logic           done_ff, nxt_done, zdiv_ff, nxt_zdiv;
    ccx_tgt_t       tgt_ff, nxt_tgt;
    logic [DW-1:0]  cmp_a, cmp_b, sub_src, bcd_add;
    logic [DW:0]    bcd_sum;
    logic           bcd_lo, bcd_hi, bit_src, cmp_lt;
    logic           div_start, div_done;
    logic [DW-1:0]  div_q, div_r;
    logic [8:0]     lo_sum;

    ccx_divider #(.WIDTH(DW)) ccx_divider_i (
        .clock     (clock),
        .resetn    (resetn),
        .start     (div_start),
        .dividend  (acc_in),
        .divisor   (b_in),
        .done      (div_done),
        .quotient  (div_q),
        .remainder (div_r)
    );

    always_comb
    begin
        // operand select for compare
        cmp_a = acc_in;
        cmp_b = imm_in;
        case (cmp_mode)
            CCX_CMP_ACC_DIR: cmp_b = direct_in;
            CCX_CMP_REG_IMM: cmp_a = working_reg_in;
            CCX_CMP_IND_IMM: cmp_a = index_mem_in;
            default:         cmp_a = acc_in;
        endcase
        cmp_lt = (cmp_a < cmp_b);
        // direct_in is the port output latch for port bytes
        case (tgt_mode)
            CCX_TGT_REG: sub_src = working_reg_in;
            CCX_TGT_DIR: sub_src = direct_in;
            CCX_TGT_IND: sub_src = index_mem_in;
            default:     sub_src = acc_in;
        endcase
        bit_src = bit_is_port ? bit_latch_in : bit_in;
        // bcd correction
        bcd_lo  = (acc_in[3:0] > CCX_NIBBLE_MAX) || nibble_carry_flag;
        lo_sum  = {1'b0, acc_in} + (bcd_lo ? {1'b0, CCX_BCD_SIX} : 9'h000);
        bcd_hi  = carry_in || lo_sum[8] || (lo_sum[7:4] > CCX_NIBBLE_MAX);
        bcd_add = (bcd_lo ? CCX_BCD_SIX : 8'h00) | (bcd_hi ? CCX_BCD_SIX_HI : 8'h00);
        bcd_sum = {1'b0, acc_in} + {1'b0, bcd_add};
    end

    always_comb
    begin
        nxt_st    = st_ff;
        nxt_pc    = pc_ff;
        nxt_acc   = acc_ff;
        nxt_b     = b_ff;
        nxt_byte  = byte_ff;
        nxt_tgt   = tgt_ff;
        nxt_bit   = bit_ff;
        nxt_c     = c_ff;
        nxt_s     = s_ff;
        nxt_zdiv  = zdiv_ff;
        nxt_pcw   = 1'b0;
        nxt_accw  = 1'b0;
        nxt_bw    = 1'b0;
        nxt_bytew = 1'b0;
        nxt_bitw  = 1'b0;
        nxt_cw    = 1'b0;
        nxt_sw    = 1'b0;
        nxt_done  = 1'b0;
        div_start = 1'b0;
        case (st_ff)
            CCX_ST_IDLE:
            begin
                if (op_valid)
                begin
                    case (op_code)
                        CCX_OP_CMP_BR:
                        begin
                            nxt_pc = pc_in + 16'(CCX_COMPARE_BRANCH_UNEQUAL_BYTES);
                            if (cmp_a != cmp_b)
                                nxt_pc = pc_in + 16'(CCX_COMPARE_BRANCH_UNEQUAL_BYTES)
                                         + {{8{rel_in[7]}}, rel_in};
                            nxt_c  = (cmp_a < cmp_b);
                            nxt_st = CCX_ST_CMP;
                        end
                        CCX_OP_ZERO_ACC:
                        begin
                            nxt_acc  = CCX_RST_BYTE;
                            nxt_accw = 1'b1;
                            nxt_done = 1'b1;
                        end
                        CCX_OP_INV_ACC:
                        begin
                            nxt_acc  = ~acc_in;
                            nxt_accw = 1'b1;
                            nxt_done = 1'b1;
                        end
                        CCX_OP_ZERO_BIT, CCX_OP_INV_BIT:
                        begin
                            nxt_bit  = (op_code == CCX_OP_INV_BIT) ? ~bit_src : 1'b0;
                            nxt_c    = (op_code == CCX_OP_INV_BIT) ? ~carry_in : 1'b0;
                            nxt_cw   = bit_is_carry;
                            nxt_bitw = !bit_is_carry;
                            nxt_done = 1'b1;
                        end
                        CCX_OP_BCD:
                        begin
                            nxt_acc  = bcd_sum[7:0];
                            nxt_accw = 1'b1;
                            nxt_c    = carry_in | bcd_sum[8] | lo_sum[8];
                            nxt_cw   = 1'b1;
                            nxt_done = 1'b1;
                        end
                        CCX_OP_SUB_ONE:
                        begin
                            nxt_byte = sub_src - 8'h01;
                            nxt_tgt  = tgt_mode;
                            nxt_bytew = 1'b1;
                            nxt_done = 1'b1;
                        end
                        CCX_OP_DIVIDE:
                        begin
                            div_start = 1'b1;
                            nxt_zdiv  = (b_in == 8'h00);
                            nxt_st    = CCX_ST_DIV;
                        end
                        default:
                            nxt_st = CCX_ST_IDLE;
                    endcase
                end
            end
            CCX_ST_CMP:
            begin
                nxt_pcw  = 1'b1;
                nxt_cw   = 1'b1;
                nxt_done = 1'b1;
                nxt_st   = CCX_ST_IDLE;
            end
            CCX_ST_DIV:
            begin
                if (div_done)
                begin
                    nxt_acc  = zdiv_ff ? CCX_DIV0_QUOT : div_q;
                    nxt_b    = zdiv_ff ? acc_in : div_r;
                    nxt_accw = 1'b1;
                    nxt_bw   = 1'b1;
                    nxt_c    = 1'b0;
                    nxt_cw   = 1'b1;
                    nxt_s    = zdiv_ff;
                    nxt_sw   = 1'b1;
                    nxt_done = 1'b1;
                    nxt_st   = CCX_ST_IDLE;
                end
            end
            default:
                nxt_st = CCX_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            st_ff    <= CCX_ST_IDLE;
            pc_ff    <= 16'h0000;
            acc_ff   <= CCX_RST_BYTE;
            b_ff     <= CCX_RST_BYTE;
            byte_ff  <= CCX_RST_BYTE;
            tgt_ff   <= CCX_TGT_ACC;
            bit_ff   <= 1'b0;
            c_ff     <= 1'b0;
            s_ff     <= 1'b0;
            zdiv_ff  <= 1'b0;
            pcw_ff   <= 1'b0;
            accw_ff  <= 1'b0;
            bw_ff    <= 1'b0;
            bytew_ff <= 1'b0;
            bitw_ff  <= 1'b0;
            cw_ff    <= 1'b0;
            sw_ff    <= 1'b0;
            done_ff  <= 1'b0;
        end
        else
        begin
            st_ff    <= nxt_st;
            pc_ff    <= nxt_pc;
            acc_ff   <= nxt_acc;
            b_ff     <= nxt_b;
            byte_ff  <= nxt_byte;
            tgt_ff   <= nxt_tgt;
            bit_ff   <= nxt_bit;
            c_ff     <= nxt_c;
            s_ff     <= nxt_s;
            zdiv_ff  <= nxt_zdiv;
            pcw_ff   <= nxt_pcw;
            accw_ff  <= nxt_accw;
            bw_ff    <= nxt_bw;
            bytew_ff <= nxt_bytew;
            bitw_ff  <= nxt_bitw;
            cw_ff    <= nxt_cw;
            sw_ff    <= nxt_sw;
            done_ff  <= nxt_done;
        end
    end

    assign busy      = (st_ff != CCX_ST_IDLE);
    assign done      = done_ff;
    assign pc_we     = pcw_ff;
    assign pc_out    = pc_ff;
    assign acc_we    = accw_ff;
    assign acc_out   = acc_ff;
    assign b_we      = bw_ff;
    assign b_out     = b_ff;
    assign byte_we   = bytew_ff;
    assign byte_tgt  = tgt_ff;
    assign byte_out  = byte_ff;
    assign bit_we    = bitw_ff;
    assign bit_out   = bit_ff;
    assign carry_we  = cw_ff;
    assign carry_out = c_ff;
    assign sign_we   = sw_ff;
    assign sign_out  = s_ff;

    cmp_two_cycle_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_CMP_BR)
        |-> ##2 (pc_we && carry_we && done)) else $error("compare not done in two cycles");
    cmp_carry_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_CMP_BR)
        |-> ##2 (carry_out == $past(cmp_lt, 2))) else $error("compare carry wrong");
    cmp_no_write_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_CMP) |-> ##1 (!acc_we && !byte_we && !b_we)) else $error("compare wrote operand");
    zero_acc_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_ZERO_ACC)
        |=> (acc_we && acc_out == 8'h00 && !carry_we && !sign_we)) else $error("zero acc failed");
    inv_acc_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_INV_ACC)
        |=> (acc_we && acc_out == ~$past(acc_in) && !carry_we)) else $error("invert acc failed");
    inv_bit_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_INV_BIT && !bit_is_carry)
        |=> (bit_we && bit_out == ~$past(bit_src) && !carry_we)) else $error("invert bit failed");
    zero_bit_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_ZERO_BIT)
        |=> ((bit_we || carry_we) && !bit_out && !carry_out && !sign_we)) else $error("zero bit failed");
    bcd_carry_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_BCD && carry_in)
        |=> (carry_we && carry_out && !sign_we)) else $error("bcd cleared carry");
    sub_one_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_SUB_ONE)
        |=> (byte_we && byte_out == $past(sub_src) - 8'h01 && !carry_we)) else $error("decrement wrong");
    div_four_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_DIVIDE)
        |-> !done ##1 !done [*3] ##1 (done && acc_we && b_we && !carry_out)) else $error("divide timing");
    div_zero_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_ff == CCX_ST_IDLE && op_valid && op_code == CCX_OP_DIVIDE && b_in == 8'h00)
        |-> ##4 (sign_we && sign_out && acc_out == CCX_DIV0_QUOT)) else $error("divide by zero");
endmodule
`default_nettype wire
